// file: src/wwat_top.sv
// watchdog supervisor with instruction-fetch address trap, apb slave
// assumes: fetch, mode and fs tick inputs come from logic on clk;
// clk is the high-frequency system clock
//
// Contract
// - enable bit holds one after reset; supervision runs at once
// - detection time field picks overflow of 2^25..2^19 fc or 2^17..2^11 fs
// - output select zero: overflow raises watchdog interrupt, no reset
// - once output select is written zero, writes of one are ignored
// - control register is write-only, reads undefined; no read-modify-write
// - disable code acts only while enable bit already holds zero
// - binary counter held cleared while the watchdog is disabled
// - watchdog interrupt is non-maskable, independent of master flag
// - new watchdog interrupt taken at once even while one is serviced
// - reset output: overflow resets hardware for at most 24 fc periods
// - ram trap select takes effect only after the arming code; reset arms it directly, without the code
// - fetch from special-function or debug area always traps
// - trap output zero: trapped fetch raises non-maskable trap interrupt
// - new trap interrupt taken at once, earlier one left nested
// - trap output one: trapped fetch resets for at most 24 fc periods
// - count pauses during stop, idle and sleep, resumes from held value
// - clear code clears only the binary counter, not the prescaler
`timescale 1ns/10ps
`include "wwat_params.svh"

module wwat_top #(
	parameter int          FC_QTR_LOG2 = 23,
	parameter int          FS_QTR_LOG2 = 15,
	parameter logic [15:0] SFR_LO      = 16'h0000,
	parameter logic [15:0] SFR_HI      = 16'h003f,
	parameter logic [15:0] RAM_LO      = 16'h0040,
	parameter logic [15:0] RAM_HI      = 16'h083f,
	parameter logic [15:0] DBR_LO      = 16'h0f80,
	parameter logic [15:0] DBR_HI      = 16'h0fff
) (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire wwat_pkg::wwat_apb_req_type apb_req,
	output wwat_pkg::wwat_apb_rsp_type      apb_rsp,
	input  wire wwat_pkg::wwat_fetch_type   fetch,
	input  wire logic                      prescaler_source_select,
	input  wire logic                      low_speed_mode_one,
	input  wire logic                      fs_tick,
	input  wire logic                      count_pause,
	output wwat_pkg::wwat_event_type        events
);

	// --------------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------------
	// below 7 the fastest selection would leave no prescaler bit to test
	if (FC_QTR_LOG2 < 7 || FC_QTR_LOG2 > 31) begin : g_fc_range
		$error("fc quarter period exponent out of range");
	end
	if (FS_QTR_LOG2 < 7 || FS_QTR_LOG2 > 31) begin : g_fs_range
		$error("fs quarter period exponent out of range");
	end

	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	// low prescaler bits that must all be set for a quarter-period tick
	function automatic logic [31:0] tick_mask(
		input logic [1:0] sel,
		input logic       slow
	);
		int lg;
		lg = (slow ? FS_QTR_LOG2 : FC_QTR_LOG2) - 2 * int'(sel);
		return (32'h1 << lg) - 32'h1;
	endfunction

	function automatic logic in_area(
		input logic [15:0] a,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		return a == `WWAT_ADDR_CTRL1 || a == `WWAT_ADDR_CODE ||
			a == `WWAT_ADDR_STAT;
	endfunction

	// --------------------------------------------------------------------
	// state
	// --------------------------------------------------------------------
	wwat_pkg::wwat_state_type s_ff;
	wwat_pkg::wwat_state_type nxt_s;

	logic        setup;
	logic        wr;
	logic        wr_ctrl;
	logic        wr_code;
	logic [7:0]  code;
	logic        slow;
	logic        adv;
	logic [31:0] m;
	logic        tick;
	logic        ovf;
	logic        trap;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.ev = '0;
		nxt_s.rsp.pready = 1'b0;
		nxt_s.rsp.pslverr = 1'b0;

		// ----- apb slave: answer one cycle after setup
		setup = apb_req.psel && !apb_req.penable;
		wr = apb_req.psel && apb_req.penable && s_ff.rsp.pready &&
			apb_req.pwrite && !s_ff.rsp.pslverr;
		wr_ctrl = wr && apb_req.paddr == `WWAT_ADDR_CTRL1;
		wr_code = wr && apb_req.paddr == `WWAT_ADDR_CODE;
		code = apb_req.pwdata[7:0];
		if (setup) begin
			nxt_s.rsp.pready = 1'b1;
			nxt_s.rsp.pslverr = !known_addr(apb_req.paddr);
			nxt_s.rsp.prdata = 32'h0;
			if (!apb_req.pwrite &&
				apb_req.paddr == `WWAT_ADDR_STAT) begin
				nxt_s.rsp.prdata[`WWAT_STAT_CNT_MSB:`WWAT_STAT_CNT_LSB] =
					s_ff.cnt;
				nxt_s.rsp.prdata[`WWAT_STAT_RUN] = s_ff.run;
				nxt_s.rsp.prdata[`WWAT_STAT_RST] = s_ff.ev.sys_reset_req;
				nxt_s.rsp.prdata[`WWAT_STAT_ARMED] = s_ff.ramarm;
			end
		end

		// ----- control register write
		if (wr_ctrl) begin
			nxt_s.outsel = apb_req.pwdata[`WWAT_BIT_OUTSEL] &&
				s_ff.outsel;
			nxt_s.time_sel =
				apb_req.pwdata[`WWAT_MSB_TIME:`WWAT_LSB_TIME];
			nxt_s.en = apb_req.pwdata[`WWAT_BIT_EN];
			nxt_s.trapout = apb_req.pwdata[`WWAT_BIT_TRAPOUT];
			nxt_s.ramsel = apb_req.pwdata[`WWAT_BIT_RAMTRAP];
			if (apb_req.pwdata[`WWAT_BIT_EN])
				nxt_s.run = 1'b1;
		end

		// ----- code register write; other values do nothing
		if (wr_code && code == `WWAT_CODE_DISABLE &&
			!s_ff.en)
			nxt_s.run = 1'b0;
		if (wr_code && code == `WWAT_CODE_ARM)
			nxt_s.ramarm = s_ff.ramsel;

		// ----- prescaler and two-stage binary counter
		slow = prescaler_source_select || low_speed_mode_one;
		adv = !count_pause && (!slow || fs_tick);
		m = tick_mask(s_ff.time_sel, slow);
		tick = adv && ((s_ff.pre & m) == m);
		ovf = 1'b0;
		if (adv)
			nxt_s.pre = s_ff.pre + 32'h1;
		if (!s_ff.run) begin
			nxt_s.cnt = 2'h0;
		end else if (wr_code && code == `WWAT_CODE_CLEAR) begin
			nxt_s.cnt = 2'h0;
		end else if (tick) begin
			ovf = s_ff.cnt == `WWAT_CNT_LAST;
			nxt_s.cnt = s_ff.cnt + 2'h1;
		end

		// ----- fetch trap decode
		trap = fetch.valid &&
			(in_area(fetch.addr, SFR_LO, SFR_HI) ||
			in_area(fetch.addr, DBR_LO, DBR_HI) ||
			(s_ff.ramarm && in_area(fetch.addr, RAM_LO, RAM_HI)));

		// ----- interrupt pulses, not gated by any mask
		nxt_s.ev.wdog_interrupt = ovf && !s_ff.outsel;
		nxt_s.ev.fetch_trap_interrupt =
			trap && !s_ff.trapout;

		// ----- reset request held a bounded number of cycles
		nxt_s.ev.sys_reset_req = s_ff.ev.sys_reset_req;
		if (s_ff.ev.sys_reset_req) begin
			if (s_ff.rstcnt == 5'h0)
				nxt_s.ev.sys_reset_req = 1'b0;
			else
				nxt_s.rstcnt = s_ff.rstcnt - 5'h1;
		end else if ((ovf && s_ff.outsel) ||
			(trap && s_ff.trapout)) begin
			nxt_s.ev.sys_reset_req = 1'b1;
			nxt_s.rstcnt = 5'(`WWAT_RST_CYCLES - 1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
			s_ff.outsel <= 1'(`WWAT_CTRL1_RST >> `WWAT_BIT_OUTSEL);
			s_ff.time_sel <= 2'(`WWAT_CTRL1_RST >> `WWAT_LSB_TIME);
			s_ff.en <= 1'(`WWAT_CTRL1_RST >> `WWAT_BIT_EN);
			s_ff.run <= 1'b1;
			s_ff.trapout <= 1'(`WWAT_CTRL1_RST >> `WWAT_BIT_TRAPOUT);
			s_ff.ramsel <= 1'(`WWAT_CTRL1_RST >> `WWAT_BIT_RAMTRAP);
			s_ff.ramarm <= 1'(`WWAT_CTRL1_RST >> `WWAT_BIT_RAMTRAP);
		end else begin
			s_ff <= nxt_s;
		end
	end

	// --------------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------------
	assign apb_rsp = s_ff.rsp;
	assign events = s_ff.ev;

endmodule

// file: common/wwat_params.svh
// offsets, field positions, codes, reset values and timing counts
// assumes: included by the watchdog top module only
`ifndef WWAT_PARAMS_SVH
`define WWAT_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define WWAT_ADDR_CTRL1    8'h34
`define WWAT_ADDR_CODE     8'h38
`define WWAT_ADDR_STAT     8'h3c

// ----------------------------------------------------------------------
// codes accepted by the code register
// ----------------------------------------------------------------------
`define WWAT_CODE_CLEAR    8'h4e
`define WWAT_CODE_DISABLE  8'hb1
`define WWAT_CODE_ARM      8'hd2

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define WWAT_BIT_OUTSEL    0
`define WWAT_LSB_TIME      1
`define WWAT_MSB_TIME      2
`define WWAT_BIT_EN        3
`define WWAT_BIT_TRAPOUT   4
`define WWAT_BIT_RAMTRAP   5
`define WWAT_CTRL1_RST     6'h39

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define WWAT_STAT_CNT_LSB  0
`define WWAT_STAT_CNT_MSB  1
`define WWAT_STAT_RUN      2
`define WWAT_STAT_RST      3
`define WWAT_STAT_ARMED    4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WWAT_CLK_NS        4
`define WWAT_RST_MAX_NS    96
`define WWAT_RST_CYCLES    (`WWAT_RST_MAX_NS / `WWAT_CLK_NS)
`define WWAT_CNT_LAST      2'h3

`endif

// file: common/wwat_pkg.sv
// types of the watchdog with address trap
// assumes: nothing; used by package-qualified names only
package wwat_pkg;

	// --------------------------------------------------------------------
	// bus and fetch carriers
	// --------------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} wwat_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} wwat_apb_rsp_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} wwat_fetch_type;

	typedef struct packed {
		logic wdog_interrupt;
		logic fetch_trap_interrupt;
		logic sys_reset_req;
	} wwat_event_type;

	// --------------------------------------------------------------------
	// whole state of the block
	// --------------------------------------------------------------------
	typedef struct packed {
		logic [31:0]      pre;
		logic [1:0]       cnt;
		logic             outsel;
		logic [1:0]       time_sel;
		logic             en;
		logic             run;
		logic             trapout;
		logic             ramsel;
		logic             ramarm;
		logic [4:0]       rstcnt;
		wwat_event_type   ev;
		wwat_apb_rsp_type rsp;
	} wwat_state_type;

endpackage

// file: test/wwat_assertions.sv
// checker on the ports of the watchdog with address trap
// assumes: bound into wwat_top, single clock domain on clk
`timescale 1ns/10ps
module wwat_assertions #(
	parameter logic [15:0] SFR_HI = 16'h003f,
	parameter logic [15:0] DBR_LO = 16'h0f80,
	parameter logic [15:0] DBR_HI = 16'h0fff
) (
	input wire logic                       clk,
	input wire logic                       rstn,
	input wire wwat_pkg::wwat_apb_req_type apb_req,
	input wire wwat_pkg::wwat_apb_rsp_type apb_rsp,
	input wire wwat_pkg::wwat_fetch_type   fetch,
	input wire logic                       count_pause,
	input wire wwat_pkg::wwat_event_type   events
);
	logic [5:0] rcnt_ff;

	// length of the current reset request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rcnt_ff <= 6'h00;
		else
			rcnt_ff <= events.sys_reset_req ? rcnt_ff + 6'h01 : 6'h00;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_pready;
		apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
	endproperty
	property p_err;
		apb_rsp.pready |-> apb_rsp.pslverr ==
			!(apb_req.paddr inside {8'h34, 8'h38, 8'h3c});
	endproperty
	property p_ctrl_rd;
		apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 8'h34
			|-> apb_rsp.prdata == 32'h0;
	endproperty
	property p_sfr;
		fetch.valid && fetch.addr <= SFR_HI && !events.sys_reset_req
			|=> events.fetch_trap_interrupt || events.sys_reset_req;
	endproperty
	property p_dbr;
		fetch.valid && fetch.addr >= DBR_LO && fetch.addr <= DBR_HI &&
			!events.sys_reset_req
			|=> events.fetch_trap_interrupt || events.sys_reset_req;
	endproperty
	property p_trap_src;
		events.fetch_trap_interrupt |-> $past(fetch.valid);
	endproperty
	property p_irq;
		events.wdog_interrupt |=> !events.wdog_interrupt;
	endproperty
	property p_pause;
		count_pause [*4] |-> !events.wdog_interrupt;
	endproperty
	property p_rlen;
		$fell(events.sys_reset_req) |-> rcnt_ff == 6'h18;
	endproperty
	property p_rmax;
		rcnt_ff <= 6'h18;
	endproperty

	a_pready: assert property (p_pready)
		else $error("no ready after setup");
	a_err: assert property (p_err)
		else $error("error response wrong");
	a_ctrl_rd: assert property (p_ctrl_rd)
		else $error("control read not zero");
	a_sfr: assert property (p_sfr)
		else $error("special area fetch not trapped");
	a_dbr: assert property (p_dbr)
		else $error("debug area fetch not trapped");
	a_trap_src: assert property (p_trap_src)
		else $error("trap without fetch");
	a_irq: assert property (p_irq)
		else $error("interrupt longer than a pulse");
	a_pause: assert property (p_pause)
		else $error("interrupt while paused");
	a_rlen: assert property (p_rlen)
		else $error("reset request length wrong");
	a_rmax: assert property (p_rmax)
		else $error("reset request too long");

	c_irq: cover property (events.wdog_interrupt);
	c_trap: cover property (events.fetch_trap_interrupt);
	c_rst: cover property ($rose(events.sys_reset_req));
endmodule

bind wwat_top wwat_assertions #(
	.SFR_HI(SFR_HI),
	.DBR_LO(DBR_LO),
	.DBR_HI(DBR_HI)
) u_chk (
	.clk(clk),
	.rstn(rstn),
	.apb_req(apb_req),
	.apb_rsp(apb_rsp),
	.fetch(fetch),
	.count_pause(count_pause),
	.events(events)
);

// file: test/watchdog_with_address_trap_tb_top.sv
// self-checking bench of the watchdog with address trap
// assumes: short prescaler counts, fs tick every fourth clock
`timescale 1ns/10ps
module watchdog_with_address_trap_tb_top;
	logic                       clk = 0, rstn = 0, src = 0, slow = 0;
	logic                       fs_tick = 0, pause = 0, e;
	logic [31:0]                q;
	wwat_pkg::wwat_apb_req_type req = '0;
	wwat_pkg::wwat_apb_rsp_type rsp;
	wwat_pkg::wwat_fetch_type   fch = '0;
	wwat_pkg::wwat_event_type   ev;
	int                         fails = 0, check_count = 0, cyc = 0, n, k;
	int                         irqs = 0;
	logic [15:0] ta [8] = '{16'h0000, 16'h003f, 16'h0040, 16'h083f,
		16'h0840, 16'h0f7f, 16'h0f80, 16'h0fff};
	logic        tx [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

	wwat_top #(.FC_QTR_LOG2(7), .FS_QTR_LOG2(7)) DUT (
		.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .fetch(fch),
		.prescaler_source_select(src), .low_speed_mode_one(slow),
		.fs_tick(fs_tick), .count_pause(pause), .events(ev));

	always #2 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		fs_tick <= (cyc % 4 == 3);
		if (ev.wdog_interrupt === 1'b1)
			irqs <= irqs + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			end_sim;
		end
	end

	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, x, g);
		end
	endtask

	// response is read at the rising edge, before that edge updates it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask

	task wait_irq;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (ev.wdog_interrupt !== 1'b1 && n < 5000);
	endtask

	// measures the reset request, then restarts the block
	task rst_len;
		n = 0;
		while (ev.sys_reset_req !== 1'b1 && n < 600) begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		while (ev.sys_reset_req === 1'b1) begin
			@(posedge clk);
			#1 n++;
		end
		chk("reset_len", 32'h18, n);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task fetch_chk(input logic [15:0] a, input logic x);
		@(posedge clk);
		fch <= '{1'b1, a};
		@(posedge clk);
		fch <= '0;
		#1 chk("trap", x, ev.fetch_trap_interrupt);
	endtask

	task t_reset;
		apb(1'b0, 8'h3c, 32'h0);
		chk("status", 32'h14, q);
		apb(1'b0, 8'h34, 32'h0);
		chk("ctrl_read", 32'h0, q);
		apb(1'b1, 8'h40, 32'h0);
		chk("slverr", 32'h1, e);
	endtask

	task t_disable;
		apb(1'b1, 8'h38, 32'hb1);
		apb(1'b0, 8'h3c, 32'h0);
		chk("run_en1", 32'h1, q[2]);
		apb(1'b1, 8'h38, 32'h4e);
		apb(1'b1, 8'h34, 32'h31);
		apb(1'b1, 8'h38, 32'h55);
		apb(1'b0, 8'h3c, 32'h0);
		chk("run_bad_code", 32'h1, q[2]);
		apb(1'b1, 8'h38, 32'hb1);
		repeat (600) @(posedge clk);
		apb(1'b0, 8'h3c, 32'h0);
		chk("status_off", 32'h10, q);
		apb(1'b1, 8'h34, 32'h3f);
		rst_len;
	endtask

	task t_period;
		for (int m = 0; m < 3; m++)
			for (int s = 3; s >= 0; s--) begin
				@(posedge clk);
				src <= (m == 1);
				slow <= (m == 2);
				apb(1'b1, 8'h34, 32'h38 | (s << 1));
				wait_irq;
				wait_irq;
				chk("period", (4 << (7 - 2 * s)) * (m > 0 ? 4 : 1), n);
			end
		@(posedge clk);
		slow <= 1'b0;
		apb(1'b1, 8'h34, 32'h3f);
		wait_irq;
		wait_irq;
		chk("period_outsel", 32'h8, n);
	endtask

	// counter is cleared just before the pause, one tick lands before it
	task t_pause;
		wait_irq;
		apb(1'b1, 8'h38, 32'h4e);
		@(posedge clk);
		pause <= 1'b1;
		k = 0;
		repeat (100) begin
			@(posedge clk);
			#1 if (ev.wdog_interrupt === 1'b1) k++;
		end
		chk("irq_in_pause", 32'h0, k);
		@(posedge clk);
		pause <= 1'b0;
		wait_irq;
		chk("resume", 32'h6, n);
	endtask

	// clears every third cycle from the main flow keep interrupts away;
	// the prescaler keeps running, so the next overflow comes one early
	task t_service;
		apb(1'b1, 8'h38, 32'h4e);
		k = irqs;
		repeat (8) apb(1'b1, 8'h38, 32'h4e);
		chk("irq_serviced", k, irqs);
		wait_irq;
		chk("first_ovf", 32'h7, n);
	endtask

	task t_trap;
		apb(1'b1, 8'h34, 32'h08);
		fetch_chk(16'h0040, 1'b1);
		apb(1'b1, 8'h38, 32'hd2);
		foreach (ta[i]) fetch_chk(ta[i], tx[i]);
		apb(1'b1, 8'h34, 32'h18);
		fetch_chk(16'h0fff, 1'b0);
		rst_len;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_disable;
		t_period;
		t_pause;
		t_service;
		t_trap;
		end_sim;
	end
endmodule
